/* File: rtl/rtdbs_pkg.sv */
// Shared constants, field layouts and carrier types of the double-buffer selector
package rtdbs_pkg;

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int              WORD_W         = 16;     // Memory word width
    localparam int              ADDR_W         = 16;     // Memory address width
    localparam int              MEM_WORDS_DFLT = 8192;   // Words swept by the reset clear
    localparam logic [15:0]     WORD_ZERO      = 16'h0000; // Cleared memory value
    localparam logic [15:0]     ADDR_ZERO      = 16'h0000; // First address of the sweep

    // ************************************************************
    // Descriptor block offsets from its base N
    // ************************************************************
    localparam logic [15:0]     DESC_CTRL_OFS  = 16'h0000; // Control word
    localparam logic [15:0]     DESC_PTR_A_OFS = 16'h0001; // Data pointer A
    localparam logic [15:0]     DESC_PTR_B_OFS = 16'h0002; // Data pointer B
    localparam logic [15:0]     DESC_BCST_OFS  = 16'h0003; // Broadcast data pointer

    // ************************************************************
    // Control word bit positions
    // ************************************************************
    localparam int              CW_NEXT_BUF_BIT   = 0;  // next_buffer_select
    localparam int              CW_ACT_IND_BIT    = 1;  // active_buffer_indicator
    localparam int              CW_DB_ACTIVE_BIT  = 2;  // double_buffer_active
    localparam int              CW_DB_PAUSE_BIT   = 3;  // double_buffer_pause
    localparam int              CW_DB_SELECT_BIT  = 4;  // double_buffer_select
    localparam int              CW_CMD_BUSY_BIT   = 5;  // per_command_busy

    // ************************************************************
    // Mode transmit information word bit positions
    // ************************************************************
    localparam int              MIW_HI_LSB     = 10; // Bits 15-10 come from the protocol engine
    localparam int              MIW_BUSY_BIT   = 9;  // responded_busy_flag
    localparam int              MIW_ILLEGAL_BIT = 8; // Illegal command received
    localparam int              MIW_UNUSED_LSB = 6;  // Bits 7-6 always zero
    localparam int              MIW_BUS_BIT    = 5;  // bus_select_flag
    localparam int              MIW_MC_LSB     = 0;  // mode_code_field, bits 4-0

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        S_CLEAR, S_IDLE, S_CW_WAIT, S_CW_TAKE, S_PTR_WAIT, S_PTR_TAKE, S_MARK,
        S_SERVE, S_END_WAIT, S_END_TAKE, S_WR_MIW, S_WR_CW
    } rtdbs_state_type;

    typedef struct packed {
        logic [15:0] desc_addr;       // Descriptor base N
        logic [4:0]  mode_code_field; // Mode code from the command word
        logic        bus_select_flag; // 0 bus A, 1 bus B
        logic        broadcast_flag;  // Broadcast command
        logic        tx;              // Transmit command
        logic        mode_cmd;        // Mode command rather than subaddress
    } rtdbs_msg_type;

    typedef struct packed {
        logic        incomplete;      // Message did not finish
        logic        illegal;         // Illegalization entry was 1
        logic        busy;            // Answered with busy status
        logic        msg_error;       // Message error status
        logic        wc_legal;        // Word count is a legal one
        logic [5:0]  miw_hi;          // Info word bits 15-10
    } rtdbs_outcome_type;

    typedef struct packed {
        logic        toggle_guard_option;
        logic        broadcast_separate_option;
        logic        broadcast_invalidate;
        logic        global_busy;     // Global busy status bit
    } rtdbs_cfg_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
    } rtdbs_mem_type;

    // Whether a finished message may flip the next-buffer bit
    function automatic logic rtdbs_toggle_ok(input logic guard, input rtdbs_outcome_type o);
        logic ok;
        ok = !o.incomplete && !o.msg_error;
        if (guard)
        begin
            ok = ok && !o.illegal && !o.busy && o.wc_legal;
        end
        return ok;
    endfunction

endpackage

/* File: rtl/rtdbs_top.sv */
// Double-buffer selection and mode transmit info word fill for one remote terminal
`timescale 1ns/100ps
// How it works
// - Busy answer sets info word bit 9
// - Illegal table entry sets bit 8
// - Bit 5 shows bus A or B
// - Mode code fills bits 4-0
// - Alternate buffers A and B per message
// - Descriptor: control, A, B, broadcast at N+3
// - Select and no pause sets active bit
// - Next-buffer 0 picks A, 1 picks B
// - Pointers A and B never written
// - Error-free message inverts next-buffer bit
// - New message overwrites selected buffer words
// - Guard set blocks toggle on bad outcomes
// - Guard clear still toggles on illegal, busy
// - Guard set toggles only on legal count
// - Reset clears the first MEM_WORDS words to zero
// - Pause clears active bit, freezes alternation
// - Unpause sets active bit, resumes alternation
// - Separated broadcasts use broadcast buffer, no toggle
module rtdbs_top #(
    parameter int MEM_WORDS = rtdbs_pkg::MEM_WORDS_DFLT  // Words cleared after reset
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire rtdbs_pkg::rtdbs_cfg_type     cfg,
    input  wire logic                        msg_start,
    input  wire rtdbs_pkg::rtdbs_msg_type     msg_in,
    input  wire logic                        msg_done,
    input  wire rtdbs_pkg::rtdbs_outcome_type outcome_in,
    input  wire logic [15:0]                 mem_rdata,
    output logic                             ready,
    output logic                             clearing,
    output rtdbs_pkg::rtdbs_mem_type          mem,
    output logic [15:0]                      buf_ptr,
    output logic                             ptr_valid,
    output logic                             responded_busy_flag,
    output logic                             done
);
    import rtdbs_pkg::*;
    // ************************************************************
    // Parameter check
    // ************************************************************
    if (MEM_WORDS < 1 || MEM_WORDS > 65536)
    begin : g_bad_size
        $error("MEM_WORDS must lie between 1 and 65536");
    end
    localparam logic [15:0] LAST_ADDR = 16'(MEM_WORDS - 1); // End of the clear sweep
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        rtdbs_state_type   state;
        rtdbs_mem_type     mem;
        rtdbs_msg_type     msg;      // Latched command
        rtdbs_outcome_type outc;     // Latched message outcome
        logic [15:0]       cw;       // Control word being worked on
        logic [15:0]       buf_ptr;
        logic              alt;      // Alternation running at message start
        logic              bpath;    // Broadcast buffer in use
        logic              use_b;    // Pointer B in use
        logic              ptr_valid;
        logic              resp_busy;
        logic              done;
        logic              ready;
        logic              clearing;
    } rtdbs_top_state_type;
    rtdbs_top_state_type s_r;        // Registered state
    rtdbs_top_state_type s_nxt;      // Next state
    // Descriptor offset of the data pointer to use
    function automatic logic [15:0] ptr_ofs(input logic [15:0] cw, input logic bpath);
        logic [15:0] o;
        o = DESC_PTR_A_OFS;
        if (bpath)
        begin
            o = DESC_BCST_OFS;
        end
        else if (cw[CW_DB_SELECT_BIT] && !cw[CW_DB_PAUSE_BIT])
        begin
            o = cw[CW_NEXT_BUF_BIT] ? DESC_PTR_B_OFS : DESC_PTR_A_OFS;
        end
        else if (cw[CW_DB_SELECT_BIT])
        begin
            // Paused: keep serving the buffer last marked active
            o = cw[CW_ACT_IND_BIT] ? DESC_PTR_B_OFS : DESC_PTR_A_OFS;
        end
        return o;
    endfunction
    logic [15:0] mode_miw;           // Mode transmit info word
    logic        bpath_now;          // Broadcast separation applies to this command
    logic        toggle_now;         // Flip decision at message end
    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        // info word bits 15-0 built here
        mode_miw = {s_r.outc.miw_hi, s_r.resp_busy, s_r.outc.illegal, 2'b00,
                    s_r.msg.bus_select_flag, s_r.msg.mode_code_field};
        // separated broadcasts take the broadcast pointer
        bpath_now = s_r.msg.broadcast_flag && cfg.broadcast_separate_option
                    && !cfg.broadcast_invalidate;
        toggle_now = s_r.alt && !s_r.bpath && rtdbs_toggle_ok(cfg.toggle_guard_option, s_r.outc);
        s_nxt           = s_r;
        s_nxt.mem.we    = 1'b0;
        s_nxt.mem.re    = 1'b0;
        s_nxt.ptr_valid = 1'b0;
        s_nxt.done      = 1'b0;
        unique case (s_r.state)
            S_CLEAR:
            begin
                // sweep zero into words 0 to LAST_ADDR, one per cycle
                s_nxt.mem.we    = 1'b1;
                s_nxt.mem.wdata = WORD_ZERO;
                if (s_r.mem.we)
                begin
                    if (s_r.mem.addr == LAST_ADDR)
                    begin
                        s_nxt.mem.we   = 1'b0;
                        s_nxt.clearing = 1'b0;
                        s_nxt.ready    = 1'b1;
                        s_nxt.state    = S_IDLE;
                    end
                    else
                    begin
                        s_nxt.mem.addr = 16'(s_r.mem.addr + 16'h0001);
                    end
                end
            end
            S_IDLE:
            begin
                // Starts are only taken while ready
                if (msg_start)
                begin
                    s_nxt.msg      = msg_in;
                    s_nxt.mem.addr = msg_in.desc_addr;
                    s_nxt.mem.re   = 1'b1;
                    s_nxt.ready    = 1'b0;
                    s_nxt.state    = S_CW_WAIT;
                end
            end
            S_CW_WAIT:
            begin
                // Memory answers one cycle after the read strobe
                s_nxt.state = S_CW_TAKE;
            end
            S_CW_TAKE:
            begin
                // pick the pointer from the fetched control word
                s_nxt.cw        = mem_rdata;
                s_nxt.alt       = mem_rdata[CW_DB_SELECT_BIT] && !mem_rdata[CW_DB_PAUSE_BIT];
                s_nxt.bpath     = bpath_now;
                s_nxt.use_b     = ptr_ofs(mem_rdata, bpath_now) == DESC_PTR_B_OFS;
                s_nxt.resp_busy = cfg.global_busy || mem_rdata[CW_CMD_BUSY_BIT];
                s_nxt.mem.addr  = 16'(s_r.msg.desc_addr + ptr_ofs(mem_rdata, bpath_now));
                s_nxt.mem.re    = 1'b1;
                s_nxt.state     = S_PTR_WAIT;
            end
            S_PTR_WAIT:
            begin
                s_nxt.state = S_PTR_TAKE;
            end
            S_PTR_TAKE:
            begin
                // pointer used as a fixed start address, never rewritten
                s_nxt.buf_ptr   = mem_rdata;
                s_nxt.ptr_valid = 1'b1;
                // confirm or withdraw alternation at start
                s_nxt.cw[CW_DB_ACTIVE_BIT] = s_r.alt;
                if (s_r.alt && !s_r.bpath)
                begin
                    s_nxt.cw[CW_ACT_IND_BIT] = s_r.use_b;
                end
                s_nxt.mem.addr  = s_r.msg.desc_addr;
                s_nxt.mem.wdata = s_nxt.cw;
                s_nxt.mem.we    = 1'b1;
                s_nxt.state     = S_MARK;
            end
            S_MARK:
            begin
                s_nxt.state = S_SERVE;
            end
            S_SERVE:
            begin
                // Protocol engine moves the data words meanwhile
                if (msg_done)
                begin
                    s_nxt.outc     = outcome_in;
                    s_nxt.mem.addr = s_r.msg.desc_addr;
                    s_nxt.mem.re   = 1'b1;
                    s_nxt.state    = S_END_WAIT;
                end
            end
            S_END_WAIT:
            begin
                s_nxt.state = S_END_TAKE;
            end
            S_END_TAKE:
            begin
                // Re-read so a pause set mid-message clears the active bit
                s_nxt.cw = mem_rdata;
                // active bit follows select and pause
                s_nxt.cw[CW_DB_ACTIVE_BIT] = mem_rdata[CW_DB_SELECT_BIT]
                                             && !mem_rdata[CW_DB_PAUSE_BIT];
                // invert next-buffer bit for the other buffer when toggle_now is set
                s_nxt.cw[CW_NEXT_BUF_BIT] = mem_rdata[CW_NEXT_BUF_BIT] ^ toggle_now;
                s_nxt.mem.we = 1'b1;
                if (s_r.msg.mode_cmd && s_r.msg.tx)
                begin
                    // info word overwrites the earlier one
                    s_nxt.mem.addr  = s_r.buf_ptr;
                    s_nxt.mem.wdata = mode_miw;
                    s_nxt.state     = S_WR_MIW;
                end
                else
                begin
                    s_nxt.mem.addr  = s_r.msg.desc_addr;
                    s_nxt.mem.wdata = s_nxt.cw;
                    s_nxt.state     = S_WR_CW;
                end
            end
            S_WR_MIW:
            begin
                s_nxt.mem.we    = 1'b1;
                s_nxt.mem.addr  = s_r.msg.desc_addr;
                s_nxt.mem.wdata = s_r.cw;
                s_nxt.state     = S_WR_CW;
            end
            S_WR_CW:
            begin
                s_nxt.done  = 1'b1;
                s_nxt.ready = 1'b1;
                s_nxt.state = S_IDLE;
            end
        endcase
    end
    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r          <= '0;
            s_r.state    <= S_CLEAR;
            s_r.clearing <= 1'b1;
            s_r.mem.addr <= ADDR_ZERO;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
    // Outputs straight from the state register
    assign ready               = s_r.ready;
    assign clearing            = s_r.clearing;
    assign mem                 = s_r.mem;
    assign buf_ptr             = s_r.buf_ptr;
    assign ptr_valid           = s_r.ptr_valid;
    assign responded_busy_flag = s_r.resp_busy;
    assign done                = s_r.done;
    // ************************************************************
    // Assertions
    // ************************************************************
    logic exp_tog;                   // Expected flip, kept apart from the package helper
    assign exp_tog = s_r.alt && !s_r.bpath && !s_r.outc.incomplete && !s_r.outc.msg_error
                     && (!cfg.toggle_guard_option
                         || (!s_r.outc.illegal && !s_r.outc.busy && s_r.outc.wc_legal));
    sequence s_accept;
        s_r.state == S_IDLE && msg_start;
    endsequence
    sequence s_end_cw;
        s_r.state == S_END_TAKE ##1 s_r.state == S_WR_CW;
    endsequence
    sequence s_end_miw_cw;
        s_r.state == S_END_TAKE ##1 s_r.state == S_WR_MIW ##1 s_r.state == S_WR_CW;
    endsequence
    property p_clear_zero;
        @(posedge clk) disable iff (!rst_n)
        (s_r.state == S_CLEAR && s_r.mem.we) |-> s_r.mem.wdata == WORD_ZERO;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear wrote nonzero");
    property p_cw_fetch;
        @(posedge clk) disable iff (!rst_n)
        s_accept |=> s_r.mem.re && s_r.mem.addr == $past(msg_in.desc_addr) ##4 ptr_valid;
    endproperty
    a_cw_fetch: assert property (p_cw_fetch) else $error("control word fetch wrong");
    property p_ptr_pick;
        @(posedge clk) disable iff (!rst_n)
        (s_r.state == S_PTR_WAIT && s_r.alt && !s_r.bpath) |->
            s_r.mem.addr == 16'(s_r.msg.desc_addr +
                                (s_r.cw[CW_NEXT_BUF_BIT] ? DESC_PTR_B_OFS : DESC_PTR_A_OFS));
    endproperty
    a_ptr_pick: assert property (p_ptr_pick) else $error("wrong data pointer read");
    property p_broadcast_flag_ptr;
        @(posedge clk) disable iff (!rst_n)
        (s_r.state == S_PTR_WAIT && s_r.bpath) |->
            s_r.mem.addr == 16'(s_r.msg.desc_addr + DESC_BCST_OFS);
    endproperty
    a_broadcast_flag_ptr: assert property (p_broadcast_flag_ptr) else $error("broadcast pointer not used");
    property p_ptr_static;
        @(posedge clk) disable iff (!rst_n)
        (s_r.mem.we && !s_r.clearing && s_r.state != S_WR_MIW) |->
            s_r.mem.addr == s_r.msg.desc_addr;
    endproperty
    a_ptr_static: assert property (p_ptr_static) else $error("pointer word written");
    property p_toggle_direct;
        @(posedge clk) disable iff (!rst_n)
        s_end_cw |-> s_r.mem.wdata[CW_NEXT_BUF_BIT] == ($past(mem_rdata[CW_NEXT_BUF_BIT]) ^ exp_tog);
    endproperty
    a_toggle_direct: assert property (p_toggle_direct) else $error("bad flip");
    property p_toggle_miw;
        @(posedge clk) disable iff (!rst_n)
        s_end_miw_cw |->
            s_r.mem.wdata[CW_NEXT_BUF_BIT] == ($past(mem_rdata[CW_NEXT_BUF_BIT], 2) ^ exp_tog);
    endproperty
    a_toggle_miw: assert property (p_toggle_miw) else $error("bad flip after mode");
    property p_active_bit;
        @(posedge clk) disable iff (!rst_n)
        s_end_cw |-> s_r.mem.wdata[CW_DB_ACTIVE_BIT] ==
            ($past(mem_rdata[CW_DB_SELECT_BIT]) && !$past(mem_rdata[CW_DB_PAUSE_BIT]));
    endproperty
    a_active_bit: assert property (p_active_bit) else $error("active bit wrong");
    property p_miw_fields;
        @(posedge clk) disable iff (!rst_n)
        (s_r.state == S_WR_MIW) |->
            s_r.mem.addr == s_r.buf_ptr
            && s_r.mem.wdata[MIW_BUSY_BIT] == s_r.resp_busy
            && s_r.mem.wdata[MIW_ILLEGAL_BIT] == s_r.outc.illegal
            && s_r.mem.wdata[MIW_BUS_BIT] == s_r.msg.bus_select_flag
            && s_r.mem.wdata[4:0] == s_r.msg.mode_code_field
            && s_r.mem.wdata[7:6] == 2'b00;
    endproperty
    a_miw_fields: assert property (p_miw_fields) else $error("info word fields wrong");
endmodule

/* File: dv/rtdbs_mem_model.sv */
// Memory partner answering the selector's read and write strobes
`timescale 1ns/100ps
module rtdbs_mem_model (
    input  wire logic                    clk,
    input  wire rtdbs_pkg::rtdbs_mem_type mem,
    output logic [15:0]                  mem_rdata
);
    import rtdbs_pkg::*;

    // ************************************************************
    // Storage
    // ************************************************************
    logic [15:0] m [0:63];   // Descriptor and buffers fit in 64 words

    // Start dirty so a missed reset clear shows up
    initial
    begin
        for (int i = 0; i < 64; i++)
            m[i] = 16'hFFFF;
        mem_rdata = 16'h0000;
    end

    always @(posedge clk)
    begin
        if (mem.we)
            m[mem.addr[5:0]] <= mem.wdata;
        // Idle read lines toggle so stale data never looks valid
        if (mem.re)
            mem_rdata <= m[mem.addr[5:0]];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the double-buffer selector
`timescale 1ns/100ps
module testbench;
    import rtdbs_pkg::*;

    // ************************************************************
    // Signals
    // ************************************************************
    localparam logic [15:0] N = 16'h0004;   // Descriptor base
    logic              clk;
    logic              rst_n;
    rtdbs_cfg_type     cfg;
    logic              msg_start;
    rtdbs_msg_type     msg_in;
    logic              msg_done;
    rtdbs_outcome_type outcome_in;
    logic [15:0]       mem_rdata;
    logic              ready;
    logic              clearing;
    rtdbs_mem_type     mem;
    logic [15:0]       buf_ptr;
    logic              ptr_valid;
    logic              responded_busy_flag;
    logic              done;
    int                errors = 0;
    int                check_count = 0;

    // Small sweep keeps the reset clear short
    rtdbs_top #(.MEM_WORDS(16)) dut (.clk(clk), .rst_n(rst_n), .cfg(cfg),
        .msg_start(msg_start), .msg_in(msg_in), .msg_done(msg_done),
        .outcome_in(outcome_in), .mem_rdata(mem_rdata), .ready(ready),
        .clearing(clearing), .mem(mem), .buf_ptr(buf_ptr), .ptr_valid(ptr_valid),
        .responded_busy_flag(responded_busy_flag), .done(done));
    rtdbs_mem_model mem_model (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

    // 50 ns clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic tick();
        @(posedge clk);
        #5;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait, a hang ends the run
    task automatic wait_for(input string name, ref logic sig);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < 200)
        begin
            tick();
            n++;
        end
        if (sig !== 1'b1)
        begin
            errors++;
            $display("wrong value %s expected 1 seen %b", name, sig);
            final_report();
        end
    endtask

    function automatic rtdbs_msg_type mk(input logic [4:0] mc, input logic bus,
                                         input logic bc, input logic tx, input logic md);
        return {N, mc, bus, bc, tx, md};
    endfunction

    // Flags: incomplete, illegal, busy, error, legal count
    function automatic rtdbs_outcome_type oc(input logic [4:0] f);
        return {f, 6'h2A};
    endfunction

    // One whole message, then control word {active, next} and pointers
    task automatic run(input rtdbs_msg_type mi, input rtdbs_outcome_type o,
                       input logic [15:0] exp_ptr, input logic exp_bsy,
                       input logic [1:0] exp_cw);
        msg_in = mi;
        msg_start = 1'b1;
        tick();
        msg_start = 1'b0;
        wait_for("ptr_valid", ptr_valid);
        chk("buf_ptr", exp_ptr, buf_ptr);
        chk("busy_flag", 16'(exp_bsy), 16'(responded_busy_flag));
        tick();
        chk("ptr_valid", 16'h0000, 16'(ptr_valid));
        tick();
        outcome_in = o;
        msg_done = 1'b1;
        tick();
        msg_done = 1'b0;
        wait_for("done", done);
        tick();
        chk("done", 16'h0000, 16'(done));
        chk("ready", 16'h0001, 16'(ready));
        chk("cw_bits", 16'(exp_cw), 16'({mem_model.m[4][2], mem_model.m[4][0]}));
        chk("ptr_a", 16'h0020, mem_model.m[5]);
        chk("ptr_b", 16'h0028, mem_model.m[6]);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        rst_n = 1'b0;
        cfg = '0;
        msg_start = 1'b0;
        msg_done = 1'b0;
        msg_in = '0;
        outcome_in = '0;
        repeat (2) @(posedge clk);
        #5;
        rst_n = 1'b1;
        chk("clearing", 16'h0001, 16'(clearing));
        wait_for("ready", ready);
        chk("clearing", 16'h0000, 16'(clearing));
        for (int i = 0; i < 16; i++)
            chk("cleared", 16'h0000, mem_model.m[i]);
        // Host loads the descriptor: select set, pause clear
        mem_model.m[4] = 16'h0010;
        mem_model.m[5] = 16'h0020;
        mem_model.m[6] = 16'h0028;
        mem_model.m[7] = 16'h0030;
        run(mk(5'h01, 1'b0, 1'b0, 1'b0, 1'b0), oc(5'b00001), 16'h0020, 1'b0, 2'b11);
        cfg.global_busy = 1'b1;
        run(mk(5'h12, 1'b1, 1'b0, 1'b1, 1'b1), oc(5'b01001), 16'h0028, 1'b1, 2'b10);
        chk("info_word", 16'hAB32, mem_model.m[40]);
        cfg = '0;
        cfg.toggle_guard_option = 1'b1;
        run(mk(5'h01, 1'b0, 1'b0, 1'b0, 1'b0), oc(5'b00101), 16'h0020, 1'b0, 2'b10);
        run(mk(5'h01, 1'b0, 1'b0, 1'b0, 1'b0), oc(5'b00000), 16'h0020, 1'b0, 2'b10);
        cfg.broadcast_separate_option = 1'b1;
        run(mk(5'h01, 1'b0, 1'b1, 1'b0, 1'b0), oc(5'b00001), 16'h0030, 1'b0, 2'b10);
        // Pause: last alternated buffer was A
        mem_model.m[4] = mem_model.m[4] | 16'h0008;
        run(mk(5'h01, 1'b0, 1'b0, 1'b0, 1'b0), oc(5'b00001), 16'h0020, 1'b0, 2'b00);
        mem_model.m[4] = mem_model.m[4] & 16'hFFF7;
        run(mk(5'h01, 1'b0, 1'b0, 1'b0, 1'b0), oc(5'b00001), 16'h0020, 1'b0, 2'b11);
        // Invalidated broadcast takes the next-buffer pointer B; per-command busy answered, guard blocks the flip
        cfg.broadcast_invalidate = 1'b1;
        mem_model.m[4] = mem_model.m[4] | 16'h0020;
        run(mk(5'h01, 1'b0, 1'b1, 1'b0, 1'b0), oc(5'b00101), 16'h0028, 1'b1, 2'b11);
        // Guard off: incomplete message still keeps the buffer
        cfg.toggle_guard_option = 1'b0;
        mem_model.m[4] = mem_model.m[4] & 16'hFFDF;
        run(mk(5'h01, 1'b0, 1'b0, 1'b0, 1'b0), oc(5'b10001), 16'h0028, 1'b0, 2'b11);
        final_report();
    end
endmodule
